// ==== design/lch_defs.svh ====
/*
 * constants of the loop control command handshake: register offsets,
 * command codes, answer codes, value limits, reset values and timing.
 * assumes a 20 MHz clock and a 12-bit APB byte address.
 */
`ifndef LCH_DEFS_SVH
`define LCH_DEFS_SVH

// apb register byte offsets
`define LCH_OFF_OUTWORD 12'h000
`define LCH_OFF_INWORD  12'h004
`define LCH_OFF_STATUS  12'h008
`define LCH_OFF_CTRL    12'h00c

// operation command prefixes (upper three hex digits), commit word, all-loops target digit and command nibble
`define LCH_OP_STOP     12'hccc
`define LCH_OP_RUN      12'hccd
`define LCH_OP_MANUAL   12'hcdc
`define LCH_OP_AUTO     12'hcdd
`define LCH_OP_AT_START 12'hcfc
`define LCH_OP_AT_STOP  12'hcfd
`define LCH_CMD_COMMIT  16'hceea
`define LCH_TGT_ALL     4'ha
`define LCH_CMD_NIBBLE  4'hc

// allocation command: C g i L, group 7 is read-only
`define LCH_GRP_READ    4'h7
`define LCH_ITEM_SP     4'h7
`define LCH_ITEM_MMV    4'h8

// answer codes
`define LCH_ERR_BUSY    16'hee00
`define LCH_ERR_SET     16'hee01

// value limits
`define LCH_SP_MAX      16'h270f
`define LCH_MMV_MAX     16'h03e8

// reset values
`define LCH_PID_RST     4'hf

// timing
`define LCH_CLK_HZ      20000000
`define LCH_NV_MS       60
`define LCH_REFRESH_MS  500
`define LCH_NV_CYC      ((`LCH_CLK_HZ / 1000) * `LCH_NV_MS)
`define LCH_REFRESH_CYC ((`LCH_CLK_HZ / 1000) * `LCH_REFRESH_MS)

`endif

// ==== design/lch_pkg.sv ====
/*
 * types of the loop control command handshake.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package lch_pkg;

    typedef logic [15:0] lch_word_t;

    typedef enum logic [1:0] {
        LCH_IDLE = 2'b00,
        LCH_EVAL = 2'b01
    } lch_state_e;

    typedef enum logic [2:0] {
        LCH_K_NONE   = 3'b000,
        LCH_K_OP     = 3'b001,
        LCH_K_COMMIT = 3'b010,
        LCH_K_ALLOC  = 3'b011,
        LCH_K_DATA   = 3'b100
    } lch_kind_e;

    typedef struct packed {
        logic       nv_busy;
        logic [3:0] autotune_active;
        logic [3:0] manual;
        logic [3:0] run;
    } lch_status_s;

endpackage

// ==== design/lch_tick.sv ====
/*
 * periodic tick counter: one-cycle tick every CYCLES clocks while run_i.
 * assumes run_i is synchronous; dropping run_i clears the count.
 */
`timescale 1ns/100ps
module lch_tick #(
    parameter int unsigned CYCLES = 16
) (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output logic      tick_o
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else if (cnt_r == W'(CYCLES - 1)) begin
            cnt_r  <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule

// ==== design/lch_top.sv ====
/*
 * command handshake of a four-loop temperature controller: the host writes
 * a 16-bit command word over APB, the block answers in a 16-bit reply word.
 * assumes process values, controller outputs and autotune completion come
 * from the loop controllers, synchronous to clock_i.
 */
// Decided for this implementation: register access over APB and the address map.
// How it works
// - accepted operation command is echoed into the reply word
// - value written under a command applies when the next command is acknowledged
// - decode stop, run, manual, auto, autotune start/cancel and setpoint commit
// - last digit 1 to 4 picks one loop, A picks all loops
// - after reset all loops are in auto mode and stopped
// - all-loops command executes nowhere if one loop fails, answers setting error
// - manual/auto or write allocation aimed at one autotuning running loop answers EE00
// - autotune start/cancel needs PID, running, auto, else answers EE01
// - manual loop drives manual manipulated value, running or stopped
// - rejected command during autotuning puts error code instead of echo
// - autotune restarts on completion while its command stays in the word
// - after autotune ack, data words belong to the previous allocation command
// - setpoint commit stores to nonvolatile memory, busy at least 60 ms
// - data word after setpoint allocation is answered with the process value
// - unchanged word after monitoring refreshes process value every 500 ms
// - out-of-range data answers EE01 and is discarded
`timescale 1ns/100ps
`include "lch_defs.svh"
module lch_top #(
    parameter int unsigned NV_CYC      = `LCH_NV_CYC,
    parameter int unsigned REFRESH_CYC = `LCH_REFRESH_CYC
) (
    input  wire logic           clock_i,
    input  wire logic           rstn_i,
    input  wire logic [11:0]    paddr_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [31:0]    pwdata_i,
    output logic [31:0]         prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    input  wire logic [63:0]    pv_i,
    input  wire logic [63:0]    ctrl_mv_i,
    input  wire logic [3:0]     at_done_i,
    output logic [63:0]         mv_o,
    output logic [63:0]         target_setpoint_o,
    output lch_pkg::lch_status_s status_o,
    output logic                sp_commit_o
);
    import lch_pkg::*;

    lch_word_t  out_word_r;
    lch_word_t  seen_r;
    lch_word_t  resp_r;
    lch_state_e state_r;
    logic [3:0] run_r;
    logic [3:0] manual_r;
    logic [3:0] at_r;
    logic [3:0] at_live_r;
    logic [3:0] pid_r;
    lch_word_t  alloc_r;
    logic       alloc_v_r;
    lch_word_t  pend_val_r;
    logic [3:0] pend_item_r;
    logic [1:0] pend_loop_r;
    logic       pend_v_r;
    logic       mon_r;
    logic [1:0] mon_loop_r;
    logic       nv_busy_r;
    logic [15:0] sp_r  [4];
    logic [15:0] mmv_r [4];
    logic [15:0] mv_r  [4];
    logic       refresh_tick;
    logic       nv_done;

    ////////////////////////////////////////////////////////////////////////
    // decode of the word under evaluation

    lch_kind_e  kind;
    logic [11:0] opc;
    logic [3:0] tgt;
    logic [3:0] mask;
    logic       tgt_ok;
    logic [3:0] busy_at;
    logic [3:0] f00;
    logic [3:0] f01;
    logic       op_ok;
    lch_word_t  op_err;
    logic [1:0] aloop;
    logic       a_write;
    logic       alloc_ok;
    lch_word_t  alloc_err;
    logic [1:0] dloop;
    logic       data_ok;
    logic       ev;
    logic       accept;
    logic [3:0] at_keep;

    assign ev = (state_r == LCH_EVAL);
    assign busy_at = at_r & run_r & pid_r;
    assign at_keep = at_r & ~(at_done_i & ~at_live_r);

    always_comb begin
        opc = seen_r[15:4];
        tgt = seen_r[3:0];
        mask = 4'h0;
        tgt_ok = 1'b0;
        if (tgt == `LCH_TGT_ALL) begin
            mask = 4'hf;
            tgt_ok = 1'b1;
        end else if (tgt >= 4'h1 && tgt <= 4'h4) begin
            mask = 4'h1 << (tgt - 4'h1);
            tgt_ok = 1'b1;
        end
        if (seen_r == `LCH_CMD_COMMIT) begin
            kind = LCH_K_COMMIT;
        end else if (opc == `LCH_OP_STOP || opc == `LCH_OP_RUN || opc == `LCH_OP_MANUAL
                     || opc == `LCH_OP_AUTO || opc == `LCH_OP_AT_START || opc == `LCH_OP_AT_STOP) begin
            kind = LCH_K_OP;
        end else if (seen_r[15:12] == `LCH_CMD_NIBBLE && seen_r[11:8] <= `LCH_GRP_READ) begin
            kind = LCH_K_ALLOC;
        end else if (alloc_v_r) begin
            kind = LCH_K_DATA;
        end else begin
            kind = LCH_K_NONE;
        end
        f00 = 4'h0;
        f01 = 4'h0;
        if (opc == `LCH_OP_MANUAL || opc == `LCH_OP_AUTO) begin
            f00 = mask & busy_at;
        end
        if (opc == `LCH_OP_AT_START || opc == `LCH_OP_AT_STOP) begin
            f01 = mask & (~pid_r | ~run_r | manual_r);
        end
        // one failing loop blocks an all-loops command everywhere
        op_ok = tgt_ok && f00 == 4'h0 && f01 == 4'h0;
        op_err = (!tgt_ok || tgt == `LCH_TGT_ALL || f01 != 4'h0) ? `LCH_ERR_SET : `LCH_ERR_BUSY;
        aloop = 2'(seen_r[3:0] - 4'h1);
        a_write = seen_r[11:8] != `LCH_GRP_READ;
        alloc_ok = 1'b0;
        alloc_err = `LCH_ERR_SET;
        if (seen_r[3:0] >= 4'h1 && seen_r[3:0] <= 4'h4) begin
            if (a_write && busy_at[aloop]) begin
                alloc_err = `LCH_ERR_BUSY;
            end else begin
                alloc_ok = 1'b1;
            end
        end
        dloop = 2'(alloc_r[3:0] - 4'h1);
        if (alloc_r[11:8] == `LCH_GRP_READ) begin
            data_ok = 1'b1;
        end else if (alloc_r[7:4] == `LCH_ITEM_SP) begin
            data_ok = seen_r <= `LCH_SP_MAX;
        end else if (alloc_r[7:4] == `LCH_ITEM_MMV) begin
            data_ok = seen_r <= `LCH_MMV_MAX;
        end else begin
            data_ok = 1'b0;
        end
        accept = ev && ((kind == LCH_K_OP && op_ok) || kind == LCH_K_COMMIT
                        || (kind == LCH_K_ALLOC && alloc_ok));
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state per access

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o   <= 1'b0;
            pslverr_o  <= 1'b0;
            prdata_o   <= 32'h0000_0000;
            out_word_r <= 16'h0000;
            pid_r      <= `LCH_PID_RST;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            if (paddr_i == `LCH_OFF_OUTWORD) begin
                prdata_o <= {16'h0000, out_word_r};
            end else if (paddr_i == `LCH_OFF_INWORD) begin
                prdata_o <= {16'h0000, resp_r};
            end else if (paddr_i == `LCH_OFF_STATUS) begin
                prdata_o <= {19'h0_0000, status_o};
            end else if (paddr_i == `LCH_OFF_CTRL) begin
                prdata_o <= {28'h000_0000, pid_r};
            end else begin
                pslverr_o <= 1'b1;
            end
        end else if (psel_i && penable_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            if (pwrite_i && paddr_i == `LCH_OFF_OUTWORD) begin
                out_word_r <= pwdata_i[15:0];
            end else if (pwrite_i && paddr_i == `LCH_OFF_CTRL) begin
                pid_r <= pwdata_i[3:0];
            end
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // update cycle: a changed word is snapshotted, then evaluated

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= LCH_IDLE;
            seen_r  <= 16'h0000;
        end else begin
            case (state_r)
                LCH_IDLE: begin
                    if (out_word_r != seen_r) begin
                        seen_r  <= out_word_r;
                        state_r <= LCH_EVAL;
                    end
                end
                default: begin
                    state_r <= LCH_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply word

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resp_r <= 16'h0000;
        end else if (ev) begin
            case (kind)
                LCH_K_OP:     resp_r <= op_ok ? seen_r : op_err;
                LCH_K_COMMIT: resp_r <= seen_r;
                LCH_K_ALLOC:  resp_r <= alloc_ok ? seen_r : alloc_err;
                LCH_K_DATA:   resp_r <= data_ok ? pv_i[{dloop, 4'h0} +: 16] : `LCH_ERR_SET;
                default:      resp_r <= resp_r;
            endcase
        end else if (mon_r && refresh_tick) begin
            resp_r <= pv_i[{mon_loop_r, 4'h0} +: 16];
        end
    end

    // refresh runs only while the answered word stays put
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mon_r      <= 1'b0;
            mon_loop_r <= 2'b00;
        end else if (ev) begin
            mon_r      <= kind == LCH_K_DATA && data_ok;
            mon_loop_r <= dloop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loop mode state

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_r     <= 4'h0;
            manual_r  <= 4'h0;
            at_r      <= 4'h0;
            at_live_r <= 4'h0;
        end else begin
            at_r <= at_keep;
            if (ev) begin
                at_live_r <= (accept && kind == LCH_K_OP && opc == `LCH_OP_AT_START) ? mask : 4'h0;
            end
            if (accept && kind == LCH_K_OP) begin
                case (opc)
                    `LCH_OP_STOP: begin
                        run_r <= run_r & ~mask;
                        at_r  <= at_keep & ~mask;
                    end
                    `LCH_OP_RUN:      run_r    <= run_r | mask;
                    `LCH_OP_MANUAL:   manual_r <= manual_r | mask;
                    `LCH_OP_AUTO:     manual_r <= manual_r & ~mask;
                    `LCH_OP_AT_START: at_r     <= at_keep | mask;
                    default:          at_r     <= at_keep & ~mask;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // allocation context and deferred data

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alloc_r   <= 16'h0000;
            alloc_v_r <= 1'b0;
        end else if (accept && kind == LCH_K_ALLOC) begin
            // operation commands leave the context alone
            alloc_r   <= seen_r;
            alloc_v_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_v_r    <= 1'b0;
            pend_val_r  <= 16'h0000;
            pend_item_r <= 4'h0;
            pend_loop_r <= 2'b00;
        end else if (accept) begin
            pend_v_r <= 1'b0;
        end else if (ev && kind == LCH_K_DATA && data_ok && alloc_r[11:8] != `LCH_GRP_READ) begin
            pend_v_r    <= 1'b1;
            pend_val_r  <= seen_r;
            pend_item_r <= alloc_r[7:4];
            pend_loop_r <= dloop;
        end
    end

    // storage is per loop; manual entry keeps the present output level unless a manual value is pending for that loop
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 4; i++) begin
                sp_r[i]  <= 16'h0000;
                mmv_r[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (accept && pend_v_r && pend_loop_r == 2'(i) && pend_item_r == `LCH_ITEM_SP) begin
                    sp_r[i] <= pend_val_r;
                end
                if (accept && pend_v_r && pend_loop_r == 2'(i) && pend_item_r == `LCH_ITEM_MMV) begin
                    mmv_r[i] <= pend_val_r;
                end else if (accept && kind == LCH_K_OP && opc == `LCH_OP_MANUAL && mask[i] && !manual_r[i]) begin
                    mmv_r[i] <= mv_r[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // manipulated value per loop

    for (genvar g = 0; g < 4; g++) begin : g_loop
        always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
                mv_r[g] <= 16'h0000;
            end else if (manual_r[g]) begin
                mv_r[g] <= mmv_r[g];
            end else if (run_r[g]) begin
                mv_r[g] <= ctrl_mv_i[16*g +: 16];
            end else begin
                mv_r[g] <= 16'h0000;
            end
        end
        assign mv_o[16*g +: 16] = mv_r[g];
        assign target_setpoint_o[16*g +: 16] = sp_r[g];
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile setpoint commit

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp_commit_o <= 1'b0;
            nv_busy_r   <= 1'b0;
        end else begin
            sp_commit_o <= accept && kind == LCH_K_COMMIT;
            if (accept && kind == LCH_K_COMMIT) begin
                nv_busy_r <= 1'b1;  // a new commit wins over completion
            end else if (nv_done) begin
                nv_busy_r <= 1'b0;
            end
        end
    end

    lch_tick #(.CYCLES(NV_CYC)) u_nv (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .run_i   (nv_busy_r && !sp_commit_o),
        .tick_o  (nv_done)
    );

    lch_tick #(.CYCLES(REFRESH_CYC)) u_refresh (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .run_i   (mon_r),
        .tick_o  (refresh_tick)
    );

    assign status_o = '{nv_busy: nv_busy_r, autotune_active: at_r, manual: manual_r, run: run_r};

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_echo;
        @(posedge clock_i) disable iff (!rstn_i)
        (ev && kind == LCH_K_OP && op_ok) |=> resp_r == $past(seen_r);
    endproperty
    a_echo: assert property (p_echo) else $error("accepted command not echoed");

    property p_busy_code;
        @(posedge clock_i) disable iff (!rstn_i)
        (ev && kind == LCH_K_OP && tgt != `LCH_TGT_ALL && f00 != 4'h0) |=> resp_r == `LCH_ERR_BUSY;
    endproperty
    a_busy_code: assert property (p_busy_code) else $error("mode change during autotune not refused");

    property p_all_none;
        @(posedge clock_i) disable iff (!rstn_i)
        (ev && kind == LCH_K_OP && tgt == `LCH_TGT_ALL && !op_ok)
            |=> $stable(run_r) && $stable(manual_r) && resp_r == `LCH_ERR_SET;
    endproperty
    a_all_none: assert property (p_all_none) else $error("all-loops command partly executed");

    property p_at_refuse;
        @(posedge clock_i) disable iff (!rstn_i)
        (ev && kind == LCH_K_OP && opc == `LCH_OP_AT_START && f01 != 4'h0 && at_done_i == 4'h0)
            |=> $stable(at_r) && resp_r == `LCH_ERR_SET;
    endproperty
    a_at_refuse: assert property (p_at_refuse) else $error("autotune started on stopped or manual loop");

    property p_manual_mv;
        @(posedge clock_i) disable iff (!rstn_i)
        manual_r[1] ##1 manual_r[1] |-> mv_r[1] == $past(mmv_r[1]);
    endproperty
    a_manual_mv: assert property (p_manual_mv) else $error("manual value not driven");

    property p_nv_busy;
        @(posedge clock_i) disable iff (!rstn_i)
        sp_commit_o |-> nv_busy_r [*8];
    endproperty
    a_nv_busy: assert property (p_nv_busy) else $error("commit busy ended early");

    property p_refresh;
        @(posedge clock_i) disable iff (!rstn_i)
        (mon_r && refresh_tick && !ev) |=> resp_r == $past(pv_i[{mon_loop_r, 4'h0} +: 16]);
    endproperty
    a_refresh: assert property (p_refresh) else $error("process value not refreshed");

    property p_change;
        @(posedge clock_i) disable iff (!rstn_i)
        (state_r == LCH_IDLE && out_word_r != seen_r) |=> ev ##1 !ev;
    endproperty
    a_change: assert property (p_change) else $error("changed word not evaluated");

    property p_at_repeat;
        @(posedge clock_i) disable iff (!rstn_i)
        (at_r[0] && at_live_r[0] && !ev && !accept) |=> at_r[0];
    endproperty
    a_at_repeat: assert property (p_at_repeat) else $error("autotune not repeated");

endmodule

// ==== testbench/lch_loop_model.sv ====
/*
 * loop controller stand-in: process values, controller outputs, autotune done.
 * assumes the bench pulses bump_i and done_req_i for one cycle each.
 */
`timescale 1ns/100ps
module lch_loop_model (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        bump_i,
    input  wire logic        done_req_i,
    output logic [63:0]      pv_o,
    output logic [63:0]      ctrl_mv_o,
    output logic [3:0]       at_done_o
);
    // distinct values per loop, so a wrong loop index shows up
    assign ctrl_mv_o = 64'h0040_0030_0020_0010;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pv_o      <= 64'h0444_0333_0222_0123;
            at_done_o <= 4'h0;
        end else begin
            if (bump_i) begin
                pv_o[15:0] <= pv_o[15:0] + 16'h0001;
            end
            at_done_o <= {3'b000, done_req_i};
        end
    end
endmodule

// ==== testbench/test_lch_top.sv ====
/*
 * self-checking bench of the command handshake over apb.
 * assumes short counts for the nonvolatile and refresh timers.
 */
`timescale 1ns/100ps
module test_lch_top;
    import lch_pkg::*;
    localparam int unsigned NV  = 20;
    localparam int unsigned REF = 30;
    logic clock_i = 1'b0, rstn_i = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bump = 1'b0, done_req = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, err, sp_commit;
    logic [63:0] pv, cmv, mv, tsp;
    logic [3:0] at_done;
    lch_status_s status;
    int fails = 0, checked = 0, cycles = 0, commits = 0;
    always #25 clock_i = ~clock_i;
    lch_top #(.NV_CYC(NV), .REFRESH_CYC(REF)) uut (.clock_i(clock_i), .rstn_i(rstn_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pv_i(pv), .ctrl_mv_i(cmv), .at_done_i(at_done),
        .mv_o(mv), .target_setpoint_o(tsp), .status_o(status), .sp_commit_o(sp_commit));
    lch_loop_model loops (.clock_i(clock_i), .rstn_i(rstn_i), .bump_i(bump), .done_req_i(done_req),
        .pv_o(pv), .ctrl_mv_o(cmv), .at_done_o(at_done));
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reply is fixed two edges after the write; four leaves margin
    task automatic cmd(input string nm, input logic [15:0] w, input logic [31:0] exp);
        apb(1'b1, 12'h000, {16'h0000, w});
        repeat (4) @(posedge clock_i);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(nm, q, exp);
    endtask
    task automatic stat(input string nm, input logic [31:0] exp);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(nm, q, exp);
    endtask
    // one-cycle strobe to the loop model: bump (0) or autotune done (1)
    task automatic pulse(input logic sel_done);
        @(posedge clock_i);
        bump <= !sel_done;
        done_req <= sel_done;
        @(posedge clock_i);
        bump <= 1'b0;
        done_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        if (sp_commit === 1'b1) begin
            commits++;
        end
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        stat("status after reset", 32'h0000_0000);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("ctrl reset", q, 32'h0000_000f);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
        cmd("alloc echo", 16'hc071, 32'h0000_c071);
        cmd("data reply pv", 16'h0064, 32'h0000_0123);
        pulse(1'b0);
        repeat (REF + 8) @(posedge clock_i);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("pv refresh", q, 32'h0000_0124);
        cmd("out of range", 16'h2710, 32'h0000_ee01);
        cmd("run all", 16'hccda, 32'h0000_ccda);
        chk("setpoint applied", {16'h0000, tsp[15:0]}, 32'h0000_0064);
        cmd("autotune start", 16'hcfc1, 32'h0000_cfc1);
        pulse(1'b1);
        repeat (4) @(posedge clock_i);
        stat("autotune repeats", 32'h0000_010f);
        cmd("data after autotune", 16'h0050, 32'h0000_0124);
        cmd("manual in autotune", 16'hcdc1, 32'h0000_ee00);
        cmd("write alloc in autotune", 16'hc071, 32'h0000_ee00);
        cmd("read alloc after autotune", 16'hc771, 32'h0000_c771);
        chk("autotune data applied", {16'h0000, tsp[15:0]}, 32'h0000_0050);
        cmd("stop loop4", 16'hccc4, 32'h0000_ccc4);
        cmd("all loops refused", 16'hcfca, 32'h0000_ee01);
        stat("nothing executed", 32'h0000_0107);
        cmd("autotune stopped", 16'hcfc4, 32'h0000_ee01);
        cmd("manual loop2", 16'hcdc2, 32'h0000_cdc2);
        chk("manual mv held", {16'h0000, mv[31:16]}, 32'h0000_0020);
        cmd("stop loop2", 16'hccc2, 32'h0000_ccc2);
        chk("manual mv stopped", {16'h0000, mv[31:16]}, 32'h0000_0020);
        cmd("commit echo", 16'hceea, 32'h0000_ceea);
        chk("commit pulse", commits, 32'h0000_0001);
        stat("commit busy", 32'h0000_1125);
        repeat (NV + 6) @(posedge clock_i);
        stat("commit done", 32'h0000_0125);
        close_out();
    end
endmodule
